// file: logic/ggs_cfg.svh
// Constants for the gigabit advertisement and status register slice.
// Assumes inclusion by bare name from the design modules ggs_idle_cnt and ggs_regs; the package does not include it.
`ifndef GGS_CFG_SVH
`define GGS_CFG_SVH

// Register indices; byte address is four times the index
`define GGS_IDX_GIG_CTRL    6'h09
`define GGS_IDX_GIG_STAT    6'h0A
`define GGS_IDX_EXT_STAT    6'h0F
`define GGS_IDX_CTRL        6'h10
`define GGS_IDX_IRQ_STAT    6'h11
`define GGS_IDX_IRQ_CLR     6'h12
`define GGS_IDX_IRQ_EN      6'h13

// Gigabit control field positions and reset values
`define GGS_GC_FD_BIT       9
`define GGS_GC_HD_BIT       8
`define GGS_GC_FD_RST       1'h1
`define GGS_GC_RSVD_RST     8'h00

// Own control register bits
`define GGS_CTRL_SWRST_BIT  0
`define GGS_CTRL_RSTAN_BIT  1
`define GGS_CTRL_PWDN_BIT   2

// Fixed extended status word
`define GGS_EXT_STAT_VAL    16'h3000

// Idle error counter ceiling
`define GGS_IDLE_MAX        8'hFF

`endif

// file: logic/ggs_pkg.sv
// Types shared by the register slice and its idle error counter.
// Assumes ggs_cfg.svh on the include path.
package ggs_pkg;
  typedef logic [15:0] ggs_half_t;

  typedef enum logic [1:0] {
    GGS_RESP_OKAY   = 2'b00,
    GGS_RESP_SLVERR = 2'b10
  } ggs_resp_t;

  typedef enum logic [1:0] {
    GGS_IRQ_FAULT = 2'b00,
    GGS_IRQ_SAT   = 2'b01,
    GGS_IRQ_LINK  = 2'b10,
    GGS_IRQ_APPLY = 2'b11
  } ggs_irq_t;
endpackage : ggs_pkg

// file: logic/ggs_idle_cnt.sv
// Saturating idle error counter, cleared by a status read.
// Assumes inc_i and clr_i come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ggs_cfg.svh"
module ggs_idle_cnt
  import ggs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       inc_i,
  input  wire logic       clr_i,
  output var  logic [7:0] cnt_o,
  output var  logic       sat_o
);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_o <= 8'h00;
    end else if (clr_i) begin
      // An error in the clearing cycle opens the next interval
      cnt_o <= inc_i ? 8'h01 : 8'h00; // [R17]
    end else if (inc_i && cnt_o != `GGS_IDLE_MAX) begin
      cnt_o <= cnt_o + 8'h01; // [R11] [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sat_o <= 1'b0;
    end else begin
      sat_o <= inc_i && !clr_i && (cnt_o == `GGS_IDLE_MAX - 8'h01);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_cnt_saturate: assert property (cnt_o == `GGS_IDLE_MAX && !clr_i |=> cnt_o == `GGS_IDLE_MAX) // [R12]
    else $error("idle count left its ceiling without a clear");
  a_cnt_clear: assert property (clr_i |=> cnt_o == ($past(inc_i) ? 8'h01 : 8'h00)) // [R11] [R17]
    else $error("idle count not cleared by read");
  a_cnt_step: assert property (!clr_i && inc_i && cnt_o != `GGS_IDLE_MAX |=> cnt_o == $past(cnt_o) + 8'h01) // [R11]
    else $error("idle count missed an error");
  c_cnt_full: cover property (sat_o);

endmodule : ggs_idle_cnt
`default_nettype wire

// file: logic/ggs_regs.sv
// Gigabit advertisement, gigabit status and extended status registers behind AXI4-Lite.
// Assumes status inputs come from PHY core logic on CORE_CLK_I; only the strap is a pin.
// Function
// R1: Full-duplex advertise bit resets to one.
// R2: Advertise writes apply only on four events.
// R3: Half-duplex advertise loads strap at reset.
// R4: Reserved low byte resets zero, survives soft reset.
// R5: Fault flag latches high, clears on read.
// R6: Bit 14 shows master/slave resolution.
// R7: Bit 13 shows local receiver status.
// R8: Bit 12 shows remote receiver status.
// R9: Bit 11 shows partner full-duplex ability.
// R10: Bit 10 shows partner half-duplex ability.
// R11: Idle count since last read, read clears.
// R12: Idle counter saturates at all ones.
// R13: Extended status bits 15:14 read zero.
// R14: Extended status bits 13:12 read one.
// R15: Extended status bits 11:0 read zero.
// R16: Gigabit status answers as register ten.
// R17: Read returns then clears; concurrent events kept.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ggs_cfg.svh"
module ggs_regs
  import ggs_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        SRST_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output var  logic        S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output var  logic        S_AXI_WREADY_O,
  output var  logic [1:0]  S_AXI_BRESP_O,
  output var  logic        S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output var  logic        S_AXI_ARREADY_O,
  output var  logic [31:0] S_AXI_RDATA_O,
  output var  logic [1:0]  S_AXI_RRESP_O,
  output var  logic        S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        STRAP_GIG_HALF_ADV_I,
  input  wire logic        LINK_UP_I,
  input  wire logic        MS_FAULT_I,
  input  wire logic        MS_MASTER_I,
  input  wire logic        LOCAL_RX_OK_I,
  input  wire logic        REMOTE_RX_OK_I,
  input  wire logic        LP_GIG_FD_I,
  input  wire logic        LP_GIG_HD_I,
  input  wire logic        IDLE_ERR_I,
  output var  logic        ADV_GIG_FD_O,
  output var  logic        ADV_GIG_HD_O,
  output var  logic        SW_RESET_O,
  output var  logic        RESTART_AN_O,
  output var  logic        POWER_DOWN_O,
  output var  logic        IRQ_O
);

  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic [5:0]  wr_idx;
  logic        wr_mapped;
  logic        rd_fire;
  logic [5:0]  rd_idx;
  logic        rd_mapped;
  ggs_half_t   rd_word;
  logic        gs_rd;
  logic        strap_s1;
  logic        strap_s2;
  logic        ctl_fd;
  logic        ctl_hd;
  logic [7:0]  ctl_rsvd;
  logic        adv_fd;
  logic        adv_hd;
  logic        sw_rst;
  logic        restart_an;
  logic        pwr_down;
  logic        pd_q;
  logic        link_q;
  logic        link_drop;
  logic        apply;
  logic        fault;
  logic [7:0]  idle_cnt;
  logic        cnt_sat;
  logic [3:0]  irq_ev;
  logic [3:0]  irq_status;
  logic [3:0]  irq_en;
  logic        irq;

  assign ADV_GIG_FD_O   = adv_fd;
  assign ADV_GIG_HD_O   = adv_hd;
  assign SW_RESET_O     = sw_rst;
  assign RESTART_AN_O   = restart_an;
  assign POWER_DOWN_O   = pwr_down;
  assign IRQ_O          = irq;

  // Write path: address and data taken in either order, one write in flight
  assign wr_fire = !S_AXI_AWREADY_O && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
  assign wr_idx  = aw_addr[7:2];

  always_comb begin
    case (wr_idx)
      `GGS_IDX_GIG_CTRL, `GGS_IDX_GIG_STAT, `GGS_IDX_EXT_STAT,
      `GGS_IDX_CTRL, `GGS_IDX_IRQ_STAT, `GGS_IDX_IRQ_CLR,
      `GGS_IDX_IRQ_EN: wr_mapped = 1'b1;
      default:         wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      S_AXI_AWREADY_O <= 1'b1;
      aw_addr         <= 8'h00;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      S_AXI_AWREADY_O <= 1'b0;
      aw_addr         <= S_AXI_AWADDR_I;
    end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
      S_AXI_AWREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      S_AXI_WREADY_O <= 1'b1;
      w_data         <= 32'h00000000;
      w_strb         <= 4'h0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      S_AXI_WREADY_O <= 1'b0;
      w_data         <= S_AXI_WDATA_I;
      w_strb         <= S_AXI_WSTRB_I;
    end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
      S_AXI_WREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= GGS_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID_O <= 1'b1;
      // Writes to read-only words are dropped but still answered OKAY
      S_AXI_BRESP_O  <= wr_mapped ? GGS_RESP_OKAY : GGS_RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // Read path
  assign rd_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign rd_idx  = S_AXI_ARADDR_I[7:2];
  assign gs_rd   = rd_fire && (rd_idx == `GGS_IDX_GIG_STAT); // [R16]

  always_comb begin
    rd_mapped = 1'b1;
    case (rd_idx)
      `GGS_IDX_GIG_CTRL: rd_word = {6'h00, ctl_fd, ctl_hd, ctl_rsvd};
      `GGS_IDX_GIG_STAT: rd_word = {fault, MS_MASTER_I, LOCAL_RX_OK_I, REMOTE_RX_OK_I,
                                    LP_GIG_FD_I, LP_GIG_HD_I, 2'b00, idle_cnt}; // [R6] [R7] [R8] [R9] [R10] [R16]
      `GGS_IDX_EXT_STAT: rd_word = `GGS_EXT_STAT_VAL; // [R13] [R14] [R15]
      `GGS_IDX_CTRL:     rd_word = {13'h0000, pwr_down, 2'b00};
      `GGS_IDX_IRQ_STAT: rd_word = {12'h000, irq_status};
      `GGS_IDX_IRQ_CLR:  rd_word = 16'h0000;
      `GGS_IDX_IRQ_EN:   rd_word = {12'h000, irq_en};
      default: begin
        rd_word   = 16'h0000;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h00000000;
      S_AXI_RRESP_O   <= GGS_RESP_OKAY;
    end else if (rd_fire) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b1;
      S_AXI_RDATA_O   <= {16'h0000, rd_word}; // [R17]
      S_AXI_RRESP_O   <= rd_mapped ? GGS_RESP_OKAY : GGS_RESP_SLVERR;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O  <= 1'b0;
    end
  end

  // Strap pin synchroniser; no reset so it keeps sampling while reset is held
  always_ff @(posedge CORE_CLK_I) begin
    strap_s1 <= STRAP_GIG_HALF_ADV_I;
    strap_s2 <= strap_s1;
  end

  // Written advertisement and reserved byte
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      ctl_fd   <= `GGS_GC_FD_RST; // [R1]
      ctl_hd   <= strap_s2; // [R3]
      ctl_rsvd <= `GGS_GC_RSVD_RST; // [R4]
    end else if (wr_fire && wr_idx == `GGS_IDX_GIG_CTRL) begin
      if (w_strb[1]) begin
        ctl_fd <= w_data[`GGS_GC_FD_BIT];
        ctl_hd <= w_data[`GGS_GC_HD_BIT];
      end
      if (w_strb[0]) begin
        ctl_rsvd <= w_data[7:0]; // [R4]
      end
    end
  end

  // Own control word: pulses for soft reset and restart, level for power down
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      sw_rst     <= 1'b0;
      restart_an <= 1'b0;
      pwr_down   <= 1'b0;
    end else begin
      sw_rst     <= wr_fire && wr_idx == `GGS_IDX_CTRL && w_strb[0] &&
                    w_data[`GGS_CTRL_SWRST_BIT];
      restart_an <= wr_fire && wr_idx == `GGS_IDX_CTRL && w_strb[0] &&
                    w_data[`GGS_CTRL_RSTAN_BIT];
      if (wr_fire && wr_idx == `GGS_IDX_CTRL && w_strb[0]) begin
        pwr_down <= w_data[`GGS_CTRL_PWDN_BIT];
      end
    end
  end

  // Edge history; link_q resets low so a reset never looks like a link loss
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      pd_q   <= 1'b0;
      link_q <= 1'b0;
    end else begin
      pd_q   <= pwr_down;
      link_q <= LINK_UP_I;
    end
  end

  assign link_drop = link_q && !LINK_UP_I;
  assign apply     = sw_rst || restart_an || (pd_q && !pwr_down) || link_drop; // [R2]

  // Advertisement seen by the negotiation logic
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      adv_fd <= `GGS_GC_FD_RST; // [R1]
      adv_hd <= strap_s2; // [R3]
    end else if (apply) begin
      adv_fd <= ctl_fd; // [R2]
      adv_hd <= ctl_hd; // [R2]
    end
  end

  // Fault flag: a new fault wins over read or soft-reset clear
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      fault <= 1'b0;
    end else if (MS_FAULT_I) begin
      fault <= 1'b1; // [R5] [R17]
    end else if (gs_rd || sw_rst) begin
      fault <= 1'b0; // [R5]
    end
  end

  ggs_idle_cnt u_idle_cnt (
    .clk_i  (CORE_CLK_I),
    .srst_i (SRST_I),
    .inc_i  (IDLE_ERR_I),
    .clr_i  (gs_rd || sw_rst),
    .cnt_o  (idle_cnt),
    .sat_o  (cnt_sat)
  );

  // Interrupt status: set beats a write-one clear in the same cycle
  assign irq_ev[GGS_IRQ_FAULT] = MS_FAULT_I;
  assign irq_ev[GGS_IRQ_SAT]   = cnt_sat;
  assign irq_ev[GGS_IRQ_LINK]  = link_drop;
  assign irq_ev[GGS_IRQ_APPLY] = apply;

  for (genvar i = 0; i < 4; i++) begin : g_irq
    always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
        irq_status[i] <= 1'b0;
      end else if (irq_ev[i]) begin
        irq_status[i] <= 1'b1;
      end else if (wr_fire && wr_idx == `GGS_IDX_IRQ_CLR && w_strb[0] && w_data[i]) begin
        irq_status[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      irq_en <= 4'h0;
    end else if (wr_fire && wr_idx == `GGS_IDX_IRQ_EN && w_strb[0]) begin
      irq_en <= w_data[3:0];
    end
  end

  // Registered output costs one cycle of interrupt latency
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_en);
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);

  a_fd_reset_one: assert property ($past(SRST_I) |-> ctl_fd && adv_fd) // [R1]
    else $error("full-duplex advertise not one after reset");
  a_adv_hold_quiet: assert property (!apply |=> $stable(adv_fd) && $stable(adv_hd)) // [R2]
    else $error("advertisement changed without an update event");
  a_adv_take_write: assert property (apply |=> adv_fd == $past(ctl_fd) && adv_hd == $past(ctl_hd)) // [R2]
    else $error("advertisement did not take written value");
  a_hd_strap_load: assert property ($past(SRST_I) |-> ctl_hd == $past(strap_s2) && adv_hd == ctl_hd) // [R3]
    else $error("half-duplex advertise not loaded from strap");
  a_rsvd_soft_keep: assert property (sw_rst |=> ctl_rsvd == $past(ctl_rsvd)) // [R4]
    else $error("reserved byte lost across soft reset");
  a_fault_latch_high: assert property (MS_FAULT_I |=> fault [*1] ##1 (fault || $past(gs_rd || sw_rst))) // [R5]
    else $error("fault flag did not latch");
  a_fault_read_clear: assert property (gs_rd && !MS_FAULT_I |=> !fault && S_AXI_RDATA_O[15] == $past(fault)) // [R5] [R17]
    else $error("fault flag not returned then cleared by read");
  a_status_live_bits: assert property (gs_rd |=> S_AXI_RDATA_O[14:10] == $past({MS_MASTER_I,
      LOCAL_RX_OK_I, REMOTE_RX_OK_I, LP_GIG_FD_I, LP_GIG_HD_I}) && S_AXI_RDATA_O[9:8] == 2'b00) // [R6] [R7] [R8] [R9] [R10]
    else $error("gigabit status live bits wrong");
  a_idle_read_clear: assert property (gs_rd |=> S_AXI_RDATA_O[7:0] == $past(idle_cnt) &&
      idle_cnt == ($past(IDLE_ERR_I) ? 8'h01 : 8'h00)) // [R11] [R17]
    else $error("idle count not returned then cleared");
  a_ext_fixed_word: assert property (rd_fire && rd_idx == `GGS_IDX_EXT_STAT |=>
      S_AXI_RDATA_O == 32'h00003000 && S_AXI_RRESP_O == GGS_RESP_OKAY) // [R13] [R14] [R15]
    else $error("extended status word wrong");
  a_status_addr_ten: assert property (rd_fire && S_AXI_ARADDR_I == 8'h28 |-> gs_rd) // [R16]
    else $error("gigabit status not decoded at register ten");
  a_irq_level_out: assert property (##1 irq == |($past(irq_status) & $past(irq_en)))
    else $error("interrupt output disagrees with status and enable");

  c_adv_applied: cover property (apply && (ctl_fd != adv_fd));
  c_fault_read: cover property (fault && gs_rd);
  c_read_with_event: cover property (gs_rd && IDLE_ERR_I);
  c_irq_raised: cover property ($rose(irq));

endmodule : ggs_regs
`default_nettype wire

// file: bench/ggs_host_model.sv
// Management host model: speaks AXI4-Lite to the register slice.
// Assumes the slice answers with registered ready and valid outputs.
`timescale 1ns/1ps
`default_nettype none
module ggs_host_model (
  input  wire logic        clk_i,
  output var  logic [7:0]  awaddr_o,
  output var  logic        awvalid_o,
  input  wire logic        awready_i,
  output var  logic [31:0] wdata_o,
  output var  logic [3:0]  wstrb_o,
  output var  logic        wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output var  logic        bready_o,
  output var  logic [7:0]  araddr_o,
  output var  logic        arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output var  logic        rready_o
);
  initial begin
    awaddr_o  = 8'h00;
    awvalid_o = 1'b0;
    wdata_o   = 32'h0000_0000;
    wstrb_o   = 4'h0;
    wvalid_o  = 1'b0;
    bready_o  = 1'b0;
    araddr_o  = 8'h00;
    arvalid_o = 1'b0;
    rready_o  = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] resp);
    @(posedge clk_i);
    awaddr_o  <= a;
    awvalid_o <= 1'b1;
    // Reserved low byte of gigabit control always written as zero
    wdata_o   <= {16'h0000, d[15:8], (a == 8'h24) ? 8'h00 : d[7:0]};
    wstrb_o   <= 4'h3;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
    end while (bvalid_i !== 1'b1);
    resp = bresp_i;
    bready_o <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'b0;
    end while (rvalid_i !== 1'b1);
    d = rdata_i;
    resp = rresp_i;
    rready_o <= 1'b0;
  endtask : rd
endmodule : ggs_host_model
`default_nettype wire

// file: bench/gig_phy_adv_status_regs_tb.sv
// Self-checking bench for the gigabit advertisement and status slice.
// Assumes the host model for bus cycles; status inputs driven here.
`timescale 1ns/1ps
`default_nettype none
module gig_phy_adv_status_regs_tb;
  import ggs_pkg::*;
  logic        clk, srst, strap, link, fault, idle_err;
  logic [4:0]  live;
  logic        adv_fd, adv_hd, irq;
  logic        sw_pulse, an_pulse, pd_lvl;
  int          sw_seen = 0;
  int          an_seen = 0;
  logic [7:0]  awaddr_o, araddr_o;
  logic [31:0] wdata_o, rdata_i;
  logic [3:0]  wstrb_o;
  logic [1:0]  bresp_i, rresp_i, resp;
  logic        awvalid_o, awready_i, wvalid_o, wready_i, bvalid_i, bready_o;
  logic        arvalid_o, arready_i, rvalid_i, rready_o;
  logic [31:0] rd_data;
  logic [15:0] vals [4];
  int          err_total = 0;
  int          checked = 0;

  ggs_host_model host (.clk_i(clk), .awaddr_o, .awvalid_o, .awready_i, .wdata_o, .wstrb_o,
    .wvalid_o, .wready_i, .bresp_i, .bvalid_i, .bready_o, .araddr_o, .arvalid_o, .arready_i,
    .rdata_i, .rresp_i, .rvalid_i, .rready_o);

  ggs_regs dut (.CORE_CLK_I(clk), .SRST_I(srst), .S_AXI_AWADDR_I(awaddr_o),
    .S_AXI_AWVALID_I(awvalid_o), .S_AXI_AWREADY_O(awready_i), .S_AXI_WDATA_I(wdata_o),
    .S_AXI_WSTRB_I(wstrb_o), .S_AXI_WVALID_I(wvalid_o), .S_AXI_WREADY_O(wready_i),
    .S_AXI_BRESP_O(bresp_i), .S_AXI_BVALID_O(bvalid_i), .S_AXI_BREADY_I(bready_o),
    .S_AXI_ARADDR_I(araddr_o), .S_AXI_ARVALID_I(arvalid_o), .S_AXI_ARREADY_O(arready_i),
    .S_AXI_RDATA_O(rdata_i), .S_AXI_RRESP_O(rresp_i), .S_AXI_RVALID_O(rvalid_i),
    .S_AXI_RREADY_I(rready_o), .STRAP_GIG_HALF_ADV_I(strap), .LINK_UP_I(link),
    .MS_FAULT_I(fault), .MS_MASTER_I(live[4]), .LOCAL_RX_OK_I(live[3]),
    .REMOTE_RX_OK_I(live[2]), .LP_GIG_FD_I(live[1]), .LP_GIG_HD_I(live[0]),
    .IDLE_ERR_I(idle_err), .ADV_GIG_FD_O(adv_fd), .ADV_GIG_HD_O(adv_hd), .SW_RESET_O(sw_pulse),
    .RESTART_AN_O(an_pulse), .POWER_DOWN_O(pd_lvl), .IRQ_O(irq));

  // Pulses last one cycle, so count them rather than sample them
  always @(posedge clk) begin
    if (sw_pulse === 1'b1) sw_seen++;
    if (an_pulse === 1'b1) an_seen++;
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input ggs_resp_t er);
    host.rd(a, rd_data, resp);
    chk(rd_data, exp);
    chk({30'h0, resp}, {30'h0, er});
  endtask : rdchk

  task automatic wrchk(input logic [7:0] a, input logic [15:0] d, input ggs_resp_t er);
    host.wr(a, d, resp);
    chk({30'h0, resp}, {30'h0, er});
  endtask : wrchk

  task automatic print_verdict();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    srst = 1'b1;
    strap = 1'b1;
    link = 1'b1;
    fault = 1'b0;
    idle_err = 1'b0;
    live = 5'h00;
    vals = '{16'h0000, 16'h0200, 16'h0100, 16'h0300};
    // Three edges so the strap synchroniser settles before release
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({30'h0, adv_fd, adv_hd}, 32'h3);
    rdchk(8'h24, 32'h0300, GGS_RESP_OKAY);
    rdchk(8'h3C, 32'h3000, GGS_RESP_OKAY);
    rdchk(8'h50, 32'h0, GGS_RESP_SLVERR);
    for (int i = 0; i < 5; i++) begin
      live <= 5'h01 << i;
      rdchk(8'h28, 32'h0400 << i, GGS_RESP_OKAY);
    end
    live <= 5'h00;
    wrchk(8'h48, 16'h000F, GGS_RESP_OKAY);
    // Each of the four apply events in turn
    for (int i = 0; i < 4; i++) begin
      wrchk(8'h24, vals[i], GGS_RESP_OKAY);
      repeat (3) @(posedge clk);
      chk({30'h0, adv_fd, adv_hd}, (i == 0) ? 32'h3 : {30'h0, vals[i-1][9:8]});
      case (i)
        0: wrchk(8'h40, 16'h0001, GGS_RESP_OKAY);
        1: wrchk(8'h40, 16'h0002, GGS_RESP_OKAY);
        2: begin
          wrchk(8'h40, 16'h0004, GGS_RESP_OKAY);
          chk({31'h0, pd_lvl}, 32'h1);
          wrchk(8'h40, 16'h0000, GGS_RESP_OKAY);
          chk({31'h0, pd_lvl}, 32'h0);
        end
        default: link <= 1'b0;
      endcase
      repeat (3) @(posedge clk);
      chk({30'h0, adv_fd, adv_hd}, {30'h0, vals[i][9:8]});
      rdchk(8'h24, {16'h0, vals[i]}, GGS_RESP_OKAY);
    end
    link <= 1'b1;
    chk(sw_seen, 32'h1);
    chk(an_seen, 32'h1);
    rdchk(8'h44, 32'h000C, GGS_RESP_OKAY);
    fault <= 1'b1;
    idle_err <= 1'b1;
    repeat (5) @(posedge clk);
    fault <= 1'b0;
    idle_err <= 1'b0;
    rdchk(8'h28, 32'h8005, GGS_RESP_OKAY);
    rdchk(8'h28, 32'h0000, GGS_RESP_OKAY);
    // Events in the very cycle the read is taken must survive the clear
    fork
      rdchk(8'h28, 32'h0000, GGS_RESP_OKAY);
      begin
        @(posedge clk);
        fault <= 1'b1;
        idle_err <= 1'b1;
        @(posedge clk);
        fault <= 1'b0;
        idle_err <= 1'b0;
      end
    join
    rdchk(8'h28, 32'h8001, GGS_RESP_OKAY);
    wrchk(8'h48, 16'h000F, GGS_RESP_OKAY);
    idle_err <= 1'b1;
    repeat (300) @(posedge clk);
    idle_err <= 1'b0;
    rdchk(8'h28, 32'h00FF, GGS_RESP_OKAY);
    rdchk(8'h44, 32'h0002, GGS_RESP_OKAY);
    wrchk(8'h4C, 16'h0001, GGS_RESP_OKAY);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wrchk(8'h4C, 16'h0000, GGS_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wrchk(8'h4C, 16'h0001, GGS_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wrchk(8'h48, 16'h0001, GGS_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rdchk(8'h44, 32'h0002, GGS_RESP_OKAY);
    rdchk(8'h4C, 32'h0001, GGS_RESP_OKAY);
    // Read-only words ignore writes; unmapped ones refuse them
    wrchk(8'h28, 16'hFFFF, GGS_RESP_OKAY);
    wrchk(8'h3C, 16'hFFFF, GGS_RESP_OKAY);
    wrchk(8'h50, 16'h1234, GGS_RESP_SLVERR);
    rdchk(8'h28, 32'h8000, GGS_RESP_OKAY);
    rdchk(8'h3C, 32'h3000, GGS_RESP_OKAY);
    print_verdict();
  end
endmodule : gig_phy_adv_status_regs_tb
`default_nettype wire
